// file: hw/mac_datapath.sv
// Multiply-accumulate datapath: 16x16 multiplier, two 36-bit accumulators,
// ALU and saturating store. Assumes operands and op codes come synchronous
// to mclk from the instruction decoder, one operation per enabled cycle.
`timescale 1ns/100ps
module mac_datapath
  import mac_pkg::*;
(
  input  wire logic        mclk,       // Instruction clock
  input  wire logic        arst_n,     // Async reset, active low
  input  wire logic        ce,         // Clock enable, freezes state when low
  input  wire dp_op_t      op,         // Datapath operation
  input  wire alu_fn_t     alu_fn,     // ALU function for OP_ALU
  input  wire logic        alu_wide,   // ALU width: 1 = 32 bits
  input  wire logic        acc_sel,    // Destination/source accumulator
  input  wire logic        src_sel,    // ALU second operand: 0 = other acc, 1 = mem word
  input  wire logic [15:0] x_in,       // Multiplier operand x
  input  wire logic [15:0] y_in,       // Multiplier operand y
  input  wire logic [15:0] mem_in,     // Memory word for load / ALU
  input  wire logic        st_sel,     // Accumulator to store
  output logic      [15:0] st_word,    // Saturated store word
  output logic             st_sat,     // Store word was saturated
  output logic      [31:0] prod_q,     // Product register
  output logic      [35:0] acc0_q,     // Accumulator 0
  output logic      [35:0] acc1_q,     // Accumulator 1
  output logic             c_zero_q,   // Condition: zero
  output logic             c_neg_q,    // Condition: negative
  output logic             c_ovf_q,    // Condition: overflow
  output logic             c_carry_q   // Condition: carry
);
  logic [35:0] acc_q [NUM_ACC];
  logic [35:0] acc_d [NUM_ACC];
  logic [31:0] prod_d;
  logic [35:0] sel_acc;
  logic [35:0] oth_acc;
  logic [35:0] alu_b;
  logic [35:0] alu_y;
  logic [35:0] mac_sum;
  logic [35:0] st_src;
  logic        a_zero;
  logic        a_neg;
  logic        a_ovf;
  logic        a_carry;
  logic        upd_cond;

  // Saturate a 36-bit value to a 16-bit word
  function automatic logic [15:0] sat16(input logic [35:0] v);
    if (v[35:15] == {21{v[35]}}) begin
      sat16 = v[15:0];
    end else if (v[35]) begin
      sat16 = SAT_NEG;
    end else begin
      sat16 = SAT_POS;
    end
  endfunction

  function automatic logic [35:0] sext16(input logic [15:0] w);
    sext16 = {{20{w[15]}}, w};
  endfunction

  // Operands widened first so the product keeps all 32 bits whatever the cast rules
  function automatic logic [31:0] mul16(input logic [15:0] p, input logic [15:0] q);
    mul16 = $signed({{16{p[15]}}, p}) * $signed({{16{q[15]}}, q});
  endfunction

  assign prod_d  = mul16(x_in, y_in);
  assign sel_acc = acc_q[acc_sel];
  assign oth_acc = acc_q[~acc_sel];
  // Product forms combinationally so the same-cycle sum needs no wait
  assign mac_sum = sel_acc + {{4{prod_d[31]}}, prod_d};
  assign alu_b   = src_sel ? sext16(mem_in) : oth_acc;
  assign st_src  = acc_q[st_sel];
  assign st_word = sat16(st_src);
  assign st_sat  = (st_src[35:15] != {21{st_src[35]}});
  assign upd_cond = ce && (op == OP_ALU);

  alu_unit u_alu (
    .a       (sel_acc),
    .b       (alu_b),
    .fn      (alu_fn),
    .wide    (alu_wide),
    .y       (alu_y),
    .y_zero  (a_zero),
    .y_neg   (a_neg),
    .y_ovf   (a_ovf),
    .y_carry (a_carry)
  );

  always_comb begin
    for (int i = 0; i < NUM_ACC; i++) begin
      acc_d[i] = acc_q[i];
    end
    unique case (op)
      OP_MAC:  acc_d[acc_sel] = mac_sum;
      OP_LOAD: acc_d[acc_sel] = sext16(mem_in);
      OP_ALU:  acc_d[acc_sel] = alu_y;
      OP_NONE, OP_MUL: ;
      default: ;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_q[i] <= ACC_RESET;
      end
      prod_q <= 32'h0000_0000;
    end else if (ce) begin
      // Written at the edge, so the next instruction reads it directly
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_q[i] <= acc_d[i];
      end
      if (op == OP_MUL || op == OP_MAC) begin
        prod_q <= prod_d;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      c_zero_q  <= 1'b0;
      c_neg_q   <= 1'b0;
      c_ovf_q   <= 1'b0;
      c_carry_q <= 1'b0;
    end else if (upd_cond) begin
      c_zero_q  <= a_zero;
      c_neg_q   <= a_neg;
      c_ovf_q   <= a_ovf;
      c_carry_q <= a_carry;
    end
  end

  assign acc0_q = acc_q[0];
  assign acc1_q = acc_q[1];

  // Checks
  property p_prod;
    @(posedge mclk) disable iff (!arst_n)
      (ce && op == OP_MUL)
        |=> (int'($signed(prod_q)) == int'($signed($past(x_in))) * int'($signed($past(y_in))));
  endproperty
  a_prod: assert property (p_prod) else $error("product wrong");

  property p_mac0;
    @(posedge mclk) disable iff (!arst_n)
      (ce && op == OP_MAC && !acc_sel) |=> (acc0_q == $past(mac_sum));
  endproperty
  a_mac0: assert property (p_mac0) else $error("mac into acc0 wrong");

  property p_mac_other;
    @(posedge mclk) disable iff (!arst_n)
      (ce && op == OP_MAC && acc_sel) |=> $stable(acc0_q);
  endproperty
  a_mac_other: assert property (p_mac_other) else $error("other accumulator changed");

  property p_load;
    @(posedge mclk) disable iff (!arst_n)
      (ce && op == OP_LOAD && acc_sel) |=> (acc1_q == sext16($past(mem_in)));
  endproperty
  a_load: assert property (p_load) else $error("load wrong");

  property p_sat_pos;
    @(posedge mclk) disable iff (!arst_n)
      (!st_src[35] && st_src[35:15] != 21'h000000) |-> (st_word == SAT_POS && st_sat);
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("positive saturation wrong");

  property p_sat_neg;
    @(posedge mclk) disable iff (!arst_n)
      (st_src[35] && st_src[35:15] != 21'h1fffff) |-> (st_word == SAT_NEG);
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("negative saturation wrong");

  property p_alu_add;
    @(posedge mclk) disable iff (!arst_n)
      (ce && op == OP_ALU && alu_fn == ALU_ADD && !acc_sel)
        |=> (acc0_q == $past(sel_acc) + $past(alu_b));
  endproperty
  a_alu_add: assert property (p_alu_add) else $error("alu add wrong");

  property p_cond;
    @(posedge mclk) disable iff (!arst_n)
      (ce && op == OP_ALU) |=> (c_zero_q == $past(a_zero) && c_neg_q == $past(a_neg));
  endproperty
  a_cond: assert property (p_cond) else $error("conditions not updated");

  sequence s_load0;
    ce && op == OP_LOAD && !acc_sel;
  endsequence
  sequence s_store0;
    st_sel == 1'b0;
  endsequence
  property p_nolat;
    @(posedge mclk) disable iff (!arst_n)
      s_load0 |=> (s_store0 |-> st_word == $past(mem_in));
  endproperty
  a_nolat: assert property (p_nolat) else $error("loaded value not visible next cycle");
endmodule

// file: shared/mac_pkg.sv
// Constants and types for the multiply-accumulate datapath.
// Assumes a single clock domain; no software-visible registers.
package mac_pkg;
  localparam int WORD_W = 16;
  localparam int PROD_W = 32;
  localparam int ACC_W  = 36;
  localparam int NUM_ACC = 2;
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  localparam logic [35:0] ACC_RESET = 36'h0_0000_0000;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_MUL,
    OP_MAC,
    OP_LOAD,
    OP_ALU
  } dp_op_t;

  typedef enum logic [3:0] {
    ALU_ADD,
    ALU_SUB,
    ALU_AND,
    ALU_OR,
    ALU_XOR,
    ALU_NEG,
    ALU_PASS,
    ALU_NOT
  } alu_fn_t;
endpackage

// file: hw/alu_unit.sv
// ALU for 16- or 32-bit operands with result conditions.
// Assumes operands already sign-extended to accumulator width by the caller.
`timescale 1ns/100ps
module alu_unit
  import mac_pkg::*;
(
  input  wire logic [35:0] a,        // Accumulator operand
  input  wire logic [35:0] b,        // Second operand
  input  wire alu_fn_t     fn,       // Operation select
  input  wire logic        wide,     // 1: 32-bit operation, 0: 16-bit
  output logic      [35:0] y,        // Result
  output logic             y_zero,   // Result zero
  output logic             y_neg,    // Result negative
  output logic             y_ovf,    // Result overflowed chosen width
  output logic             y_carry   // Carry out of chosen width
);
  logic [36:0] sum;
  logic [31:0] amask;
  logic [35:0] c_lhs;
  logic [35:0] c_rhs;
  logic        arith;

  assign amask = wide ? 32'hffff_ffff : 32'h0000_ffff;

  always_comb begin
    sum = 37'h0_0000_0000;
    unique case (fn)
      ALU_ADD:  sum = {a[35], a} + {b[35], b};
      ALU_SUB:  sum = {a[35], a} - {b[35], b};
      ALU_AND:  sum = {1'b0, a & b};
      ALU_OR:   sum = {1'b0, a | b};
      ALU_XOR:  sum = {1'b0, a ^ b};
      ALU_NEG:  sum = 37'h0_0000_0000 - {a[35], a};
      ALU_PASS: sum = {a[35], a};
      ALU_NOT:  sum = {1'b0, ~a};
      default:  sum = {a[35], a};
    endcase
  end

  assign y       = sum[35:0];
  assign y_zero  = ((sum[31:0] & amask) == 32'h0000_0000);
  assign y_neg   = wide ? sum[31] : sum[15];
  // Carry only means something for add, subtract and negate; logic ops report none
  assign arith   = (fn == ALU_ADD) || (fn == ALU_SUB) || (fn == ALU_NEG);
  // Negate is 0 - a, so its carry is formed against a zero left operand
  assign c_lhs   = (fn == ALU_NEG) ? 36'h0_0000_0000 : a;
  assign c_rhs   = (fn == ALU_NEG) ? a : b;
  assign y_carry = arith & (wide ? (sum[32] ^ c_lhs[32] ^ c_rhs[32])
                                 : (sum[16] ^ c_lhs[16] ^ c_rhs[16]));
  assign y_ovf   = wide ? (sum[35:31] != {5{sum[31]}}) : (sum[35:15] != {21{sum[15]}});
endmodule

// file: sim/mac_datapath_dual_accumulator_bench.sv
// Self-checking bench for the multiply-accumulate datapath.
// Assumes mac_pkg is compiled first; inputs change on falling mclk edges.
`timescale 1ns/100ps
module mac_datapath_dual_accumulator_bench;
  import mac_pkg::*;
  logic        mclk, arst_n, ce, alu_wide, acc_sel, src_sel, st_sel;
  dp_op_t      op;
  alu_fn_t     alu_fn;
  logic [15:0] x_in, y_in, mem_in, st_word;
  logic        st_sat, c_zero_q, c_neg_q, c_ovf_q, c_carry_q;
  logic [31:0] prod_q;
  logic [35:0] acc0_q, acc1_q;
  int          miscompares, checks, cycles;

  mac_datapath u_mac_datapath (.mclk(mclk), .arst_n(arst_n), .ce(ce), .op(op),
    .alu_fn(alu_fn), .alu_wide(alu_wide), .acc_sel(acc_sel), .src_sel(src_sel),
    .x_in(x_in), .y_in(y_in), .mem_in(mem_in), .st_sel(st_sel), .st_word(st_word),
    .st_sat(st_sat), .prod_q(prod_q), .acc0_q(acc0_q), .acc1_q(acc1_q),
    .c_zero_q(c_zero_q), .c_neg_q(c_neg_q), .c_ovf_q(c_ovf_q), .c_carry_q(c_carry_q));

  always #5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Entered at a falling edge; one rising edge takes the op, returns at the next falling edge
  task automatic op_(input dp_op_t o, input logic s, input logic [15:0] x, y, m);
    op = o; acc_sel = s; x_in = x; y_in = y; mem_in = m;
    @(negedge mclk);
  endtask

  // Back-to-back products into both accumulators, then a frozen cycle
  task automatic t_mac;
    op_(OP_MAC, 1'b0, 16'hfffd, 16'h0007, 16'h0000);
    chk("prod", prod_q, 32'hffffffeb);
    chk("acc0", acc0_q, 36'hfffffffeb);
    op_(OP_MAC, 1'b1, 16'h8000, 16'h8000, 16'h0000);
    chk("prod", prod_q, 32'h40000000);
    chk("acc1", acc1_q, 36'h040000000);
    chk("acc0", acc0_q, 36'hfffffffeb);
    op_(OP_MAC, 1'b0, 16'h0002, 16'h0003, 16'h0000);
    chk("acc0", acc0_q, 36'hffffffff1);
    st_sel = 1'b1; #1;
    chk("st_word", st_word, 16'h7fff);
    chk("st_sat", st_sat, 1'b1);
    ce = 1'b0;
    op_(OP_MAC, 1'b0, 16'h0001, 16'h0001, 16'h0000);
    ce = 1'b1;
    chk("prod", prod_q, 32'h00000006);
    op_(OP_NONE, 1'b0, 16'h0001, 16'h0001, 16'h0000);
    chk("acc0", acc0_q, 36'hffffffff1);
  endtask

  // Direct loads, a word that fits, and both saturation directions
  task automatic t_load_sat;
    op_(OP_LOAD, 1'b1, 16'h0000, 16'h0000, 16'h8001);
    chk("acc1", acc1_q, 36'hfffff8001);
    st_sel = 1'b1; #1;
    chk("st_word", st_word, 16'h8001);
    chk("st_sat", st_sat, 1'b0);
    op_(OP_MAC, 1'b1, 16'hffff, 16'h0002, 16'h0000);
    chk("acc1", acc1_q, 36'hfffff7fff);
    chk("st_word", st_word, 16'h8000);
    op_(OP_LOAD, 1'b0, 16'h0000, 16'h0000, 16'h7fff);
    op_(OP_MAC, 1'b0, 16'h0001, 16'h0001, 16'h0000);
    st_sel = 1'b0; #1;
    chk("acc0", acc0_q, 36'h000008000);
    chk("st_word", st_word, 16'h7fff);
    chk("st_sat", st_sat, 1'b1);
  endtask

  // Each case reloads acc0 because the ALU writes its result back
  task automatic alu_case(input alu_fn_t f, input logic w, input logic [15:0] a, m,
                          input logic [35:0] r, input logic [3:0] zncv);
    op_(OP_LOAD, 1'b0, 16'h0000, 16'h0000, a);
    alu_fn = f; alu_wide = w; src_sel = 1'b1;
    op_(OP_ALU, 1'b0, 16'h0000, 16'h0000, m);
    chk("alu_result", acc0_q, r);
    chk("conditions", {c_zero_q, c_neg_q, c_ovf_q, c_carry_q}, zncv);
  endtask

  task automatic t_alu;
    alu_case(ALU_ADD, 1'b0, 16'h00f0, 16'h0f0f, 36'h000000fff, 4'b0000);
    alu_case(ALU_SUB, 1'b0, 16'h00f0, 16'h0f0f, 36'hffffff1e1, 4'b0101);
    alu_case(ALU_AND, 1'b0, 16'h00f0, 16'h0f0f, 36'h000000000, 4'b1000);
    alu_case(ALU_OR,  1'b0, 16'h00f0, 16'h0f0f, 36'h000000fff, 4'b0000);
    alu_case(ALU_XOR, 1'b0, 16'h00f0, 16'h0f0f, 36'h000000fff, 4'b0000);
    alu_case(ALU_NEG, 1'b0, 16'h00f0, 16'h0f0f, 36'hfffffff10, 4'b0101);
    alu_case(ALU_NOT, 1'b0, 16'h00f0, 16'h0000, 36'hfffffff0f, 4'b0100);
    alu_case(ALU_ADD, 1'b0, 16'h7fff, 16'h0001, 36'h000008000, 4'b0110);
    alu_case(ALU_ADD, 1'b1, 16'h7fff, 16'h0001, 36'h000008000, 4'b0000);
    alu_case(ALU_ADD, 1'b0, 16'hffff, 16'h0001, 36'h000000000, 4'b1001);
  endtask

  // Product-only op, then a 32-bit overflow built by two MACs and judged wide and narrow
  task automatic t_mul_wide;
    op_(OP_LOAD, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    op_(OP_MUL, 1'b0, 16'h0100, 16'h0100, 16'h0000);
    chk("prod", prod_q, 32'h00010000);
    chk("acc0", acc0_q, 36'h000000000);
    op_(OP_LOAD, 1'b1, 16'h0000, 16'h0000, 16'h0000);
    op_(OP_MAC, 1'b1, 16'h8000, 16'h8000, 16'h0000);
    op_(OP_MAC, 1'b1, 16'h8000, 16'h8000, 16'h0000);
    chk("acc1", acc1_q, 36'h080000000);
    alu_fn = ALU_ADD; alu_wide = 1'b1; src_sel = 1'b0;
    op_(OP_ALU, 1'b1, 16'h0000, 16'h0000, 16'h0000);
    chk("alu_result", acc1_q, 36'h080000000);
    chk("conditions", {c_zero_q, c_neg_q, c_ovf_q, c_carry_q}, 4'b0110);
    alu_fn = ALU_PASS; alu_wide = 1'b0;
    op_(OP_ALU, 1'b1, 16'h0000, 16'h0000, 16'h0000);
    chk("alu_result", acc1_q, 36'h080000000);
    chk("conditions", {c_zero_q, c_neg_q, c_ovf_q, c_carry_q}, 4'b1010);
  endtask

  // Cut a hang short well beyond the few dozen cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    mclk = 1'b0; arst_n = 1'b0; ce = 1'b1; op = OP_NONE; alu_fn = ALU_ADD;
    alu_wide = 1'b0; acc_sel = 1'b0; src_sel = 1'b0; st_sel = 1'b0;
    x_in = 16'h0000; y_in = 16'h0000; mem_in = 16'h0000;
    miscompares = 0; checks = 0; cycles = 0;
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    t_mac();
    t_load_sat();
    t_alu();
    t_mul_wide();
    complete_run();
  end
endmodule
